// ### src/pfbs_top.sv
// power flags, backup sampler, host reset and supply switch control
//
// Our own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - power-on reset restores control and adjustment registers
// - osc halt sets stopped flag
// - stopped flag clears only on write zero
// - power-on flag forces backup-low flag
// - after collapse all three flags read one
// - backup result sits in bit six, Fh
// - main low drives reset, opens main switch
// - main high closes switch, delayed reset release
// - halted osc restarts release delay count
// - backup compared in 7.8 ms window per second
// - backup flag set stops further sampling
// - single backup threshold, no hysteresis
// - main valid connects main supply via switch
// - switch-off bit opens battery link when valid
// - main low: battery link closed regardless
module pfbs_top #(
   parameter int unsigned ONE_SEC   = pfbs_pkg::ONE_SEC_CYC,     // cycles per sample period
   parameter int unsigned REL_DELAY = pfbs_pkg::REL_DELAY_CYC,   // reset release delay cycles
   parameter int unsigned WIN_LEN   = pfbs_pkg::SAMPLE_WIN_CYC,  // sample window cycles
   parameter int unsigned OSC_TMO   = pfbs_pkg::OSC_TIMEOUT_CYC  // osc halt timeout cycles
) (
   input  wire logic        core_clk_in,              // 100 mhz clock
   input  wire logic        rst_n_in,                 // internal power-on reset, active low
   input  wire logic        osc_tick_in,              // crystal oscillator level, async
   input  wire logic        main_above_rise_in,       // main supply at or above rising threshold, async
   input  wire logic        main_below_fall_in,       // main supply at or below falling threshold, async
   input  wire logic        backup_below_thr_in,      // backup under backup_threshold, async
   input  wire logic [5:0]  avs_address_in,           // word address
   input  wire logic        avs_read_in,              // read strobe
   input  wire logic        avs_write_in,             // write strobe
   input  wire logic [31:0] avs_writedata_in,         // write data
   input  wire logic [3:0]  avs_byteenable_in,        // byte lanes
   output logic      [31:0] avs_readdata_out,         // read data
   output logic             avs_waitrequest_out,      // stall
   output logic             host_reset_out_n,         // host reset, active low
   output logic             main_supply_switch_out,   // main switch closed
   output logic             battery_link_switch_out,  // battery link closed
   output logic             backup_sense_en_out,      // backup comparator enable
   output logic             irq_out                   // level interrupt
);
   // refuse timing sets the counters cannot serve: the window must fit inside the period
   if (ONE_SEC <= WIN_LEN || WIN_LEN == 0 || REL_DELAY == 0 || OSC_TMO < 2) begin : g_bad_timing
      $error("pfbs_top: bad timing parameters");
   end

   // two-flop synchronisers for all asynchronous inputs
   logic [3:0] sync1_ff;
   logic [3:0] sync2_ff;
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync1_ff <= 4'h0;
         sync2_ff <= 4'h0;
      end else begin
         sync1_ff <= {backup_below_thr_in, main_below_fall_in, main_above_rise_in, osc_tick_in};
         sync2_ff <= sync1_ff;
      end
   end
   logic osc_s, main_hi, main_lo, bak_lo;
   assign osc_s   = sync2_ff[0];
   assign main_hi = sync2_ff[1];
   assign main_lo = sync2_ff[2];
   assign bak_lo  = sync2_ff[3];

   // oscillator watchdog: no edge within the timeout means halted
   logic        osc_d_ff;
   logic [31:0] osc_cnt_ff;
   logic        osc_run_ff;
   logic        osc_edge;
   assign osc_edge = osc_s ^ osc_d_ff;
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         osc_d_ff   <= 1'b0;
         osc_cnt_ff <= 32'h0;
         osc_run_ff <= 1'b0;
      end else begin
         osc_d_ff <= osc_s;
         if (osc_edge) begin
            osc_cnt_ff <= 32'h0;
            osc_run_ff <= 1'b1;
         end else if (osc_cnt_ff >= OSC_TMO - 1) begin
            osc_run_ff <= 1'b0;
         end else begin
            osc_cnt_ff <= osc_cnt_ff + 32'h1;
         end
      end
   end
   logic osc_halt_ev;
   logic osc_run_d_ff;
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) osc_run_d_ff <= 1'b0;
      else           osc_run_d_ff <= osc_run_ff;
   end
   assign osc_halt_ev = osc_run_d_ff & ~osc_run_ff;

   // bus decode; one-cycle waitrequest then answer
   logic        ack_ff;
   logic        req;
   logic        wr_go;
   logic        rd_go;
   logic [3:0]  idx;
   assign req   = (avs_read_in | avs_write_in) & ~ack_ff;
   assign wr_go = avs_write_in & ack_ff;
   assign rd_go = avs_read_in & ack_ff;
   assign idx   = avs_address_in[3:0];
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) ack_ff <= 1'b0;
      else           ack_ff <= req;
   end
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) avs_waitrequest_out <= 1'b1;
      else           avs_waitrequest_out <= ~req;
   end

   function automatic logic hit(input logic [5:0] a, input logic [3:0] i);
      hit = (a == {2'b00, i});
   endfunction : hit

   // control register and adjustment register; restored by power-on reset
   logic [7:0] ctrl1_ff;
   logic [7:0] adj_ff;
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl1_ff <= pfbs_pkg::CTRL1_RST;
         adj_ff   <= pfbs_pkg::ADJ_RST;
      end else if (wr_go && avs_byteenable_in[0]) begin
         if (hit(avs_address_in, pfbs_pkg::ADDR_CTRL1)) ctrl1_ff <= avs_writedata_in[7:0];
         if (hit(avs_address_in, pfbs_pkg::ADDR_ADJ))   adj_ff   <= avs_writedata_in[7:0];
      end
   end
   logic wr_flags;
   assign wr_flags = wr_go & avs_byteenable_in[0] & hit(avs_address_in, pfbs_pkg::ADDR_CTRL2);

   // backup sampling schedule: window at start of each second
   logic [31:0] sec_cnt_ff;
   logic        win_end;
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) sec_cnt_ff <= 32'h0;
      else if (sec_cnt_ff >= ONE_SEC - 1) sec_cnt_ff <= 32'h0;
      else sec_cnt_ff <= sec_cnt_ff + 32'h1;
   end
   pfbs_pkg::pfbs_flags_s flags_ff;
   assign win_end = (sec_cnt_ff == WIN_LEN - 1) & ~flags_ff.backup_low_flag;
   // enable stands for exactly WIN_LEN cycles; the sample is taken in its next-to-last cycle
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) backup_sense_en_out <= 1'b0;
      else backup_sense_en_out <= (sec_cnt_ff < WIN_LEN) & ~flags_ff.backup_low_flag;
   end

   // status flags; power-on reset leaves all three at one, a set beats a clear
   logic blow_set;
   assign blow_set = win_end & bak_lo;
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         flags_ff <= '{power_on_flag: 1'b1, osc_stopped_flag: 1'b1, backup_low_flag: 1'b1};
      end else begin
         if (osc_halt_ev) flags_ff.osc_stopped_flag <= 1'b1;
         else if (wr_flags && !avs_writedata_in[pfbs_pkg::BIT_OSC_STOP])
            flags_ff.osc_stopped_flag <= 1'b0;
         if (wr_flags && !avs_writedata_in[pfbs_pkg::BIT_POWER_ON]) flags_ff.power_on_flag <= 1'b0;
         // backup flag cannot be cleared while power-on still marks the time data unreliable
         if (blow_set) flags_ff.backup_low_flag <= 1'b1;
         else if (wr_flags && !avs_writedata_in[pfbs_pkg::BIT_BLOW] && !flags_ff.power_on_flag)
            flags_ff.backup_low_flag <= 1'b0;
      end
   end

   // host reset release: delay counts only while supply valid and osc running
   pfbs_pkg::pfbs_rst_e rst_st_ff;
   logic [31:0]         rel_cnt_ff;
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_st_ff  <= pfbs_pkg::PFBS_RST_HOLD;
         rel_cnt_ff <= 32'h0;
      end else begin
         case (rst_st_ff)
            pfbs_pkg::PFBS_RST_HOLD: begin
               rel_cnt_ff <= 32'h0;
               if (main_hi && !main_lo) rst_st_ff <= pfbs_pkg::PFBS_RST_WAIT;
            end
            pfbs_pkg::PFBS_RST_WAIT: begin
               if (main_lo) rst_st_ff <= pfbs_pkg::PFBS_RST_HOLD;
               else if (!osc_run_ff) rel_cnt_ff <= 32'h0;
               else if (rel_cnt_ff >= REL_DELAY - 1) rst_st_ff <= pfbs_pkg::PFBS_RST_RUN;
               else rel_cnt_ff <= rel_cnt_ff + 32'h1;
            end
            pfbs_pkg::PFBS_RST_RUN: begin
               if (main_lo) rst_st_ff <= pfbs_pkg::PFBS_RST_HOLD;
            end
            default: rst_st_ff <= pfbs_pkg::PFBS_RST_HOLD;
         endcase
      end
   end
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) host_reset_out_n <= 1'b0;
      else host_reset_out_n <= (rst_st_ff == pfbs_pkg::PFBS_RST_RUN) & ~main_lo;
   end

   // supply switches; main switch state tracks comparator, battery link closed unless told off
   logic main_ok_ff;
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) main_ok_ff <= 1'b0;
      else if (main_lo) main_ok_ff <= 1'b0;
      else if (main_hi) main_ok_ff <= 1'b1;
   end
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         main_supply_switch_out  <= 1'b0;
         battery_link_switch_out <= 1'b1;
      end else begin
         main_supply_switch_out  <= main_ok_ff & ~main_lo;
         // battery always linked while main is lost, so the core never floats
         battery_link_switch_out <= ~(main_ok_ff & ~main_lo & ctrl1_ff[pfbs_pkg::BIT_SWOFF]);
      end
   end

   // interrupts: sticky status, enable mask, write-one clear; set wins
   logic [2:0] irq_stat_ff;
   logic [2:0] irq_en_ff;
   logic [2:0] ev;
   logic [2:0] clr;
   logic       main_lo_d_ff;
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) main_lo_d_ff <= 1'b0;
      else           main_lo_d_ff <= main_lo;
   end
   assign ev  = {main_lo & ~main_lo_d_ff, blow_set, osc_halt_ev};
   assign clr = (wr_go && avs_byteenable_in[0] && hit(avs_address_in, pfbs_pkg::ADDR_IRQ_CLR))
                ? avs_writedata_in[2:0] : 3'h0;
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_stat_ff <= 3'h0;
         irq_en_ff   <= pfbs_pkg::IRQ_EN_RST;
      end else begin
         irq_stat_ff <= ev | (irq_stat_ff & ~clr);
         if (wr_go && avs_byteenable_in[0] && hit(avs_address_in, pfbs_pkg::ADDR_IRQ_EN))
            irq_en_ff <= avs_writedata_in[2:0];
      end
   end
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) irq_out <= 1'b0;
      else           irq_out <= |(irq_stat_ff & irq_en_ff);
   end

   // read mux; unmapped addresses read zero
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0;
      if (hit(avs_address_in, pfbs_pkg::ADDR_CTRL2)) begin
         rd_mux[pfbs_pkg::BIT_BLOW]     = flags_ff.backup_low_flag;
         rd_mux[pfbs_pkg::BIT_POWER_ON] = flags_ff.power_on_flag;
         rd_mux[pfbs_pkg::BIT_OSC_STOP] = flags_ff.osc_stopped_flag;
      end else if (hit(avs_address_in, pfbs_pkg::ADDR_CTRL1)) rd_mux[7:0] = ctrl1_ff;
      else if (hit(avs_address_in, pfbs_pkg::ADDR_ADJ))      rd_mux[7:0] = adj_ff;
      else if (hit(avs_address_in, pfbs_pkg::ADDR_IRQ_STAT)) rd_mux[2:0] = irq_stat_ff;
      else if (hit(avs_address_in, pfbs_pkg::ADDR_IRQ_EN))   rd_mux[2:0] = irq_en_ff;
      else if (hit(avs_address_in, pfbs_pkg::ADDR_STATUS))
         rd_mux[3:0] = {osc_run_ff, main_ok_ff, host_reset_out_n, battery_link_switch_out};
   end
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) avs_readdata_out <= 32'h0;
      else if (req && avs_read_in) avs_readdata_out <= rd_mux;
   end

   // assertions
   a_osc_halt_sets: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      osc_halt_ev |=> flags_ff.osc_stopped_flag) else $error("osc halt did not set stopped flag");
   a_stopped_no_set: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      !$past(flags_ff.osc_stopped_flag) && !$past(osc_halt_ev) |-> !flags_ff.osc_stopped_flag)
      else $error("stopped flag set without halt");
   a_power_on_forces_low: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      flags_ff.power_on_flag |-> flags_ff.backup_low_flag) else $error("backup flag clear while power-on set");
   a_reset_on_main_low: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      main_lo |=> !host_reset_out_n && !main_supply_switch_out) else $error("main low not handled");
   a_release_needs_delay: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      $rose(host_reset_out_n) |-> $past(rst_st_ff) == pfbs_pkg::PFBS_RST_RUN) else $error("early release");
   a_halt_blocks_count: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      rst_st_ff == pfbs_pkg::PFBS_RST_WAIT && !osc_run_ff && !main_lo |=> rel_cnt_ff == 32'h0)
      else $error("delay counted while osc halted");
   a_no_sample_when_low: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      flags_ff.backup_low_flag ##1 flags_ff.backup_low_flag |-> !backup_sense_en_out)
      else $error("sampling while flag set");
   a_battery_when_low: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      main_lo |=> battery_link_switch_out) else $error("battery link open while main low");
   // switch and sampler outputs follow their conditions one cycle later
   a_main_switch_on: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      main_ok_ff && !main_lo |=> main_supply_switch_out) else $error("main switch open while supply valid");
   a_link_off_valid: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      main_ok_ff && !main_lo && ctrl1_ff[pfbs_pkg::BIT_SWOFF] |=> !battery_link_switch_out)
      else $error("battery link closed despite switch-off");
   a_sample_sets_flag: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      blow_set |=> flags_ff.backup_low_flag) else $error("low backup sample did not set flag");
endmodule : pfbs_top
`default_nettype wire

// ### src/pfbs_pkg.sv
// package: constants and types for the power flags and backup switch block
package pfbs_pkg;
   // core clock and timing
   localparam int unsigned CLK_HZ          = 100_000_000;
   localparam int unsigned SAMPLE_WIN_US   = 7800;            // backup sample window, microseconds
   localparam int unsigned SAMPLE_WIN_CYC  = SAMPLE_WIN_US * (CLK_HZ / 1_000_000);
   localparam int unsigned ONE_SEC_CYC     = CLK_HZ;          // one second of clock
   localparam int unsigned REL_DELAY_MS    = 100;             // reset release delay, milliseconds
   localparam int unsigned REL_DELAY_CYC   = REL_DELAY_MS * (CLK_HZ / 1000);
   localparam int unsigned OSC_TIMEOUT_US  = 100;             // osc edge absence means halted
   localparam int unsigned OSC_TIMEOUT_CYC = OSC_TIMEOUT_US * (CLK_HZ / 1_000_000);
   // register map (word indices on the register bus)
   localparam logic [3:0]  ADDR_CTRL2      = 4'hf;            // flag register index
   localparam logic [3:0]  ADDR_CTRL1      = 4'he;            // control register index
   localparam logic [3:0]  ADDR_ADJ        = 4'h7;            // clock adjustment register index
   localparam logic [3:0]  ADDR_IRQ_STAT   = 4'h8;
   localparam logic [3:0]  ADDR_IRQ_EN     = 4'h9;
   localparam logic [3:0]  ADDR_IRQ_CLR    = 4'ha;
   localparam logic [3:0]  ADDR_STATUS     = 4'hb;
   // field positions
   localparam int unsigned BIT_OSC_STOP    = 4;               // osc stopped in ctrl2
   localparam int unsigned BIT_POWER_ON    = 5;               // power on in ctrl2
   localparam int unsigned BIT_BLOW        = 6;               // backup low in ctrl2
   localparam int unsigned BIT_SWOFF       = 0;               // battery switch off in ctrl1
   // reset values
   localparam logic [7:0]  CTRL1_RST       = 8'h00;
   localparam logic [7:0]  ADJ_RST         = 8'h00;
   localparam logic [2:0]  IRQ_EN_RST      = 3'h0;
   // interrupt events
   localparam int unsigned EV_OSC          = 0;
   localparam int unsigned EV_BLOW         = 1;
   localparam int unsigned EV_MAIN         = 2;
   typedef enum logic [1:0] {
      PFBS_RST_HOLD = 2'b00,
      PFBS_RST_WAIT = 2'b01,
      PFBS_RST_RUN  = 2'b11
   } pfbs_rst_e;
   typedef struct packed {
      logic power_on_flag;
      logic osc_stopped_flag;
      logic backup_low_flag;
   } pfbs_flags_s;
endpackage : pfbs_pkg

// ### verif/pfbs_supply_model.sv
// far-side model: crystal, main supply comparators and backup comparator
`timescale 1ns/10ps
`default_nettype none
module pfbs_supply_model (
   input  wire logic core_clk_in,          // block clock
   input  wire logic osc_run_in,           // crystal running
   input  wire logic main_ok_in,           // main supply valid
   input  wire logic backup_low_in,        // battery under backup threshold
   output logic      osc_tick_out,         // crystal level
   output logic      main_above_rise_out,  // main at or above rising threshold
   output logic      main_below_fall_out,  // main at or below falling threshold
   output logic      backup_below_thr_out  // backup comparator result
);
   logic [1:0] div_ff  = 2'h0;
   logic       tick_ff = 1'b0;
   // crystal toggles every third cycle; a halted crystal freezes at its last level
   always @(posedge core_clk_in) begin
      if (osc_run_in) begin
         div_ff <= (div_ff == 2'h2) ? 2'h0 : div_ff + 2'h1;
         if (div_ff == 2'h2) begin
            tick_ff <= ~tick_ff;
         end
      end
   end
   assign osc_tick_out = tick_ff;
   // main supply modelled as valid or collapsed, never between thresholds
   assign main_above_rise_out  = main_ok_in;
   assign main_below_fall_out  = ~main_ok_in;
   assign backup_below_thr_out = backup_low_in;
endmodule : pfbs_supply_model
`default_nettype wire

// ### verif/pfbs_top_tb_top.sv
// self-checking bench for the power flags and backup switch block
`timescale 1ns/10ps
`default_nettype none
module pfbs_top_tb_top;
   localparam int ONE_SEC = 200;
   localparam int REL     = 50;
   localparam int WIN     = 20;
   typedef struct packed {
      logic wr; logic [5:0] addr; logic [31:0] wd; logic [31:0] mask; logic [31:0] exp;
   } pfbs_tb_row_s;
   logic core_clk_in, rst_n_in, osc_run, main_ok, bk_low, osc_tick, m_hi, m_lo, b_lo;
   logic avs_read, avs_write, avs_waitrequest_out, host_reset_out_n, main_sw, batt_sw, sense_en, irq_out;
   logic [5:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata_out, rd;
   logic [3:0]  avs_byteenable;
   int          n_errors, total_checks, cyc, n, n2;
   // ordinary register traffic: write rows act, read rows compare under a mask
   pfbs_tb_row_s rows [0:12] = '{
      '{1'b0, 6'h0f, 32'h0, 32'h70, 32'h70},        // all three flags up
      '{1'b1, 6'h0f, 32'hff, 32'h0, 32'h0},
      '{1'b0, 6'h0f, 32'h0, 32'h70, 32'h70},        // ones change nothing
      '{1'b1, 6'h0f, 32'h50, 32'h0, 32'h0},
      '{1'b0, 6'h0f, 32'h0, 32'h70, 32'h50},        // only power-on cleared
      '{1'b1, 6'h0f, 32'h0, 32'h0, 32'h0},
      '{1'b0, 6'h0f, 32'h0, 32'h70, 32'h0},         // zero clears
      '{1'b1, 6'h0e, 32'h1, 32'h0, 32'h0},
      '{1'b0, 6'h0e, 32'h0, 32'h1, 32'h1},
      '{1'b1, 6'h07, 32'ha5, 32'h0, 32'h0},
      '{1'b0, 6'h07, 32'h0, 32'hff, 32'ha5},
      '{1'b1, 6'h03, 32'hff, 32'h0, 32'h0},
      '{1'b0, 6'h03, 32'h0, 32'hffffffff, 32'h0}};  // unmapped reads zero
   pfbs_top #(.ONE_SEC(ONE_SEC), .REL_DELAY(REL), .WIN_LEN(WIN), .OSC_TMO(8)) u_pfbs_top (
      .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .osc_tick_in(osc_tick),
      .main_above_rise_in(m_hi), .main_below_fall_in(m_lo), .backup_below_thr_in(b_lo),
      .avs_address_in(avs_address), .avs_read_in(avs_read), .avs_write_in(avs_write),
      .avs_writedata_in(avs_writedata), .avs_byteenable_in(avs_byteenable),
      .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
      .host_reset_out_n(host_reset_out_n), .main_supply_switch_out(main_sw),
      .battery_link_switch_out(batt_sw), .backup_sense_en_out(sense_en), .irq_out(irq_out));
   pfbs_supply_model u_pfbs_supply_model (
      .core_clk_in(core_clk_in), .osc_run_in(osc_run), .main_ok_in(main_ok), .backup_low_in(bk_low),
      .osc_tick_out(osc_tick), .main_above_rise_out(m_hi), .main_below_fall_out(m_lo),
      .backup_below_thr_out(b_lo));
   // 100 mhz clock
   always #5 core_clk_in = ~core_clk_in;
   // hang guard: the full run needs well under two thousand cycles
   always @(posedge core_clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic tally_and_finish();
      if (n_errors == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : tally_and_finish
   // one bus cycle, entered just after an edge; an extra edge keeps strobes from toggling twice at once
   task automatic avs_xfer(input logic wr, input logic [5:0] a, input logic [31:0] wd, output logic [31:0] rdo);
      int k;
      k = 0;
      avs_address   <= a;
      avs_writedata <= wd;
      avs_write     <= wr;
      avs_read      <= ~wr;
      do begin
         @(posedge core_clk_in);
         k++;
      end while (avs_waitrequest_out !== 1'b0 && k < 50);
      rdo = avs_readdata_out;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      if (k >= 50) n_errors++;
      @(posedge core_clk_in);
   endtask : avs_xfer
   task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
      avs_xfer(1'b1, a, d, rd);
   endtask : wr_reg
   task automatic rd_chk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
      avs_xfer(1'b0, a, 32'h0, rd);
      check($sformatf("reg %0h", a), rd & m, e);
   endtask : rd_chk
   // waits for host reset (sel 0) or sense window (sel 1) to reach a level, counting cycles
   task automatic wait_for(input int sel, input logic lvl, output int k);
      k = 0;
      while (((sel == 0) ? host_reset_out_n : sense_en) !== lvl && k < 600) begin
         @(posedge core_clk_in);
         k++;
      end
      if (k >= 600) n_errors++;
   endtask : wait_for
   // reset, then the host keeps off the bus until the crystal has run a while
   task automatic do_reset();
      rst_n_in <= 1'b0;
      repeat (10) @(posedge core_clk_in);
      check("reset host_reset", {31'h0, host_reset_out_n}, 32'h0);
      check("reset battery link", {31'h0, batt_sw}, 32'h1);
      check("reset irq", {31'h0, irq_out}, 32'h0);
      rst_n_in <= 1'b1;
      repeat (20) @(posedge core_clk_in);
   endtask : do_reset
   initial begin
      core_clk_in = 1'b0; rst_n_in = 1'b0; osc_run = 1'b1; main_ok = 1'b1; bk_low = 1'b0;
      avs_read = 1'b0; avs_write = 1'b0; avs_address = 6'h00; avs_writedata = 32'h0; avs_byteenable = 4'h1;
      n_errors = 0; total_checks = 0; cyc = 0;
      do_reset();
      foreach (rows[i]) begin
         avs_xfer(rows[i].wr, rows[i].addr, rows[i].wd, rd);
         if (!rows[i].wr) check("row read", rd & rows[i].mask, rows[i].exp);
      end
      // main valid with switch-off set: main closed, battery link open
      wait_for(0, 1'b1, n);
      check("main switch", {31'h0, main_sw}, 32'h1);
      check("battery link", {31'h0, batt_sw}, 32'h0);
      // main collapse: reset low fast, link closed despite switch-off
      main_ok <= 1'b0;
      wait_for(0, 1'b0, n);
      check("fall delay", {31'h0, n <= 6}, 32'h1);
      check("main open", {31'h0, main_sw}, 32'h0);
      check("link closed", {31'h0, batt_sw}, 32'h1);
      // halted crystal: flag set, release waits for oscillation
      osc_run <= 1'b0;
      repeat (30) @(posedge core_clk_in);
      rd_chk(6'h0f, 32'h10, 32'h10);
      main_ok <= 1'b1;
      repeat (100) @(posedge core_clk_in);
      check("held in reset", {31'h0, host_reset_out_n}, 32'h0);
      check("main closed", {31'h0, main_sw}, 32'h1);
      osc_run <= 1'b1;
      wait_for(0, 1'b1, n);
      check("release delay", {31'h0, n >= REL && n <= REL + 20}, 32'h1);
      rd_chk(6'h0b, 32'hf, 32'he);
      wr_reg(6'h0f, 32'h0);
      rd_chk(6'h0f, 32'h10, 32'h0);
      // low battery caught in one window, then sampling halts
      bk_low <= 1'b1;
      wait_for(1, 1'b0, n);
      wait_for(1, 1'b1, n);
      wait_for(1, 1'b0, n);
      check("window width", n, WIN);
      repeat (5) @(posedge core_clk_in);
      rd_chk(6'h0f, 32'h40, 32'h40);
      n = 0;
      repeat (2 * ONE_SEC) begin
         @(posedge core_clk_in);
         if (sense_en !== 1'b0) n++;
      end
      check("sampling stopped", n, 32'h0);
      bk_low <= 1'b0;
      wr_reg(6'h0f, 32'h0);
      wait_for(1, 1'b1, n);
      wait_for(1, 1'b0, n);
      wait_for(1, 1'b1, n2);
      check("sample period", n + n2, ONE_SEC);
      wait_for(1, 1'b0, n);
      repeat (5) @(posedge core_clk_in);
      rd_chk(6'h0f, 32'h40, 32'h0);
      // interrupt: all three events latched, masked, then cleared
      rd_chk(6'h08, 32'h7, 32'h7);
      check("irq masked", {31'h0, irq_out}, 32'h0);
      wr_reg(6'h09, 32'h7);
      repeat (2) @(posedge core_clk_in);
      check("irq raised", {31'h0, irq_out}, 32'h1);
      wr_reg(6'h09, 32'h0);
      repeat (2) @(posedge core_clk_in);
      check("irq disabled", {31'h0, irq_out}, 32'h0);
      wr_reg(6'h09, 32'h7);
      wr_reg(6'h0a, 32'h7);
      repeat (2) @(posedge core_clk_in);
      rd_chk(6'h08, 32'h7, 32'h0);
      check("irq cleared", {31'h0, irq_out}, 32'h0);
      // second reset in mid-run restores defaults and flags
      do_reset();
      rd_chk(6'h0e, 32'hff, 32'h0);
      rd_chk(6'h07, 32'hff, 32'h0);
      rd_chk(6'h09, 32'h7, 32'h0);
      rd_chk(6'h0f, 32'h70, 32'h70);
      tally_and_finish();
   end
endmodule : pfbs_top_tb_top
`default_nettype wire
